// ### logic/sbrg_div.v
/*
 * Rate divider: a prescaler of 64, 16 or 4 followed by a 16-bit counter
 * that runs from 0 to n, giving one tick every prescale*(n+1) clocks.
 * Assumes divisor and prescale selection are stable flops on aclk.
 */
`timescale 1ns/1ps
`include "sbrg_map.vh"

module sbrg_div (
   input wire aclk,
   input wire aresetn,
   input wire restart,
   input wire [15:0] divisor,
   input wire [1:0] prescale_sel,
   output reg rate_tick,
   output reg [5:0] pre_count,
   output reg [15:0] rate_count
);

   reg [5:0] pterm;

   always @* begin
      case (prescale_sel)
         `SBRG_PSEL_64: pterm = `SBRG_PTERM_64;
         `SBRG_PSEL_16: pterm = `SBRG_PTERM_16;
         `SBRG_PSEL_4: pterm = `SBRG_PTERM_4;
         default: pterm = `SBRG_PTERM_4;
      endcase
   end

   // ****************************************************************
   // counters
   // ****************************************************************
   // >= rather than == so a shrinking divisor (wide bit cleared) cannot run away
   always @(posedge aclk) begin
      if (!aresetn || restart) begin
         pre_count <= `SBRG_RST_PRE;
         rate_count <= `SBRG_RST_CNT;
         rate_tick <= 1'b0;
      end else if (pre_count >= pterm) begin
         pre_count <= `SBRG_RST_PRE;
         if (rate_count >= divisor) begin
            rate_count <= `SBRG_RST_CNT;
            rate_tick <= 1'b1;
         end else begin
            rate_count <= rate_count + 16'h0001;
            rate_tick <= 1'b0;
         end
      end else begin
         pre_count <= pre_count + 6'h01;
         rate_tick <= 1'b0;
      end
   end

endmodule // sbrg_div

// ### logic/sbrg_map.vh
/*
 * Register map, field positions, reset values and divider constants of the
 * serial baud rate generator.
 * Assumes it is included by bare name by the design files that need it.
 */
`ifndef SBRG_MAP_VH
`define SBRG_MAP_VH

// ****************************************************************
// register byte offsets on the register bus
// ****************************************************************
`define SBRG_ADDR_W 8
`define SBRG_OFS_LOW 8'h00
`define SBRG_OFS_HIGH 8'h04
`define SBRG_OFS_CTRL 8'h08
`define SBRG_OFS_STAT 8'h0C
// word indices, the byte offsets above with the two lane bits dropped
`define SBRG_IDX_LOW 6'h00
`define SBRG_IDX_HIGH 6'h01
`define SBRG_IDX_CTRL 6'h02
`define SBRG_IDX_STAT 6'h03

// ****************************************************************
// reset values
// ****************************************************************
`define SBRG_RST_LOW 8'h00
`define SBRG_RST_HIGH 8'h00
`define SBRG_RST_CTRL 3'h0
`define SBRG_RST_PRE 6'h00
`define SBRG_RST_CNT 16'h0000

// ****************************************************************
// control register fields
// ****************************************************************
`define SBRG_CTRL_WIDE 0
`define SBRG_CTRL_HSPD 1
`define SBRG_CTRL_SYNC 2
`define SBRG_CTRL_MSB 2

// ****************************************************************
// status register fields
// ****************************************************************
`define SBRG_STAT_CNT_LSB 0
`define SBRG_STAT_CNT_MSB 15
`define SBRG_STAT_PRE_LSB 16
`define SBRG_STAT_PRE_MSB 21

// ****************************************************************
// prescale selection and terminal counts (divide by 64, 16, 4)
// ****************************************************************
`define SBRG_PSEL_64 2'h0
`define SBRG_PSEL_16 2'h1
`define SBRG_PSEL_4 2'h2
`define SBRG_PTERM_64 6'h3F
`define SBRG_PTERM_16 6'h0F
`define SBRG_PTERM_4 6'h03

// ****************************************************************
// bus response codes
// ****************************************************************
`define SBRG_RESP_OKAY 2'h0
`define SBRG_RESP_SLVERR 2'h2

`endif

// ### logic/sbrg_top.v
/*
 * Serial baud rate generator with an AXI4-Lite register slave.
 * Assumes a single 200 MHz aclk, synchronous active-low aresetn, and a bus
 * master that keeps valid and payload stable until taken.
 */
// Behaviour
// [RULE1] high divisor byte is writable, resets to zero, supplies divisor bits 15:8
// [RULE2] high byte ignored unless wide divisor select set; else low byte alone
// [RULE3] any write to the high divisor byte restarts the rate divider; the code restarts only on such writes with lane 0 strobed
// [RULE4] async, eight-bit, low speed: clock divided by 64*(n+1)
// [RULE5] async, sixteen-bit, low speed: clock divided by 16*(n+1)
// [RULE6] synchronous mode: clock divided by 4*(n+1), high speed ignored
// [RULE7] divisor n is high byte concatenated above low byte
// [RULE8] async high speed: 16*(n+1) eight-bit, 4*(n+1) sixteen-bit
// [RULE9] any write to the low divisor byte restarts the rate divider; the code restarts only on such writes with lane 0 strobed
// [RULE10] wide divisor select set picks sixteen-bit, cleared picks eight-bit
// [RULE11] high speed select chooses speed in async mode, ignored in sync
// [RULE12] sync mode select set means synchronous, cleared asynchronous
`timescale 1ns/1ps
`include "sbrg_map.vh"

module sbrg_top (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output wire rate_tick,
   output wire sync_mode
);

   // ****************************************************************
   // register state
   // ****************************************************************
   reg [7:0] divisor_low_byte;
   reg [7:0] divisor_high_byte;
   reg [`SBRG_CTRL_MSB:0] baud_control_reg;

   wire wide_divisor_select;
   wire high_speed_select;
   wire sync_mode_select;
   wire [15:0] baud_divisor;
   wire [15:0] rate_count;
   wire [5:0] pre_count;
   reg [1:0] prescale_sel;

   assign wide_divisor_select = baud_control_reg[`SBRG_CTRL_WIDE];
   assign high_speed_select = baud_control_reg[`SBRG_CTRL_HSPD];
   assign sync_mode_select = baud_control_reg[`SBRG_CTRL_SYNC];
   assign sync_mode = sync_mode_select;

   // ****************************************************************
   // write channel capture
   // ****************************************************************
   // address and data are captured separately so they may arrive in either order
   reg aw_full;
   reg w_full;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire do_write;
   wire wr_low;
   wire wr_high;
   wire wr_ctrl;
   wire wr_mapped;

   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;

   assign wr_mapped = (aw_addr[7:2] == `SBRG_IDX_LOW) || (aw_addr[7:2] == `SBRG_IDX_HIGH) ||
      (aw_addr[7:2] == `SBRG_IDX_CTRL) || (aw_addr[7:2] == `SBRG_IDX_STAT);
   // only lane 0 carries register data; a write without it stores nothing
   assign wr_low = do_write && w_strb[0] && (aw_addr[7:2] == `SBRG_IDX_LOW);
   assign wr_high = do_write && w_strb[0] && (aw_addr[7:2] == `SBRG_IDX_HIGH);
   assign wr_ctrl = do_write && w_strb[0] && (aw_addr[7:2] == `SBRG_IDX_CTRL);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_full <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SBRG_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? `SBRG_RESP_OKAY : `SBRG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // register writes
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         divisor_high_byte <= `SBRG_RST_HIGH; // [RULE1]
         divisor_low_byte <= `SBRG_RST_LOW;
         baud_control_reg <= `SBRG_RST_CTRL;
      end else begin
         if (wr_high) begin
            divisor_high_byte <= w_data[7:0]; // [RULE1]
         end
         if (wr_low) begin
            divisor_low_byte <= w_data[7:0];
         end
         if (wr_ctrl) begin
            baud_control_reg <= w_data[`SBRG_CTRL_MSB:0];
         end
      end
   end

   // ****************************************************************
   // divisor and prescale selection
   // ****************************************************************
   // high byte is masked, not cleared, so it returns when the wide bit is set again
   assign baud_divisor = wide_divisor_select ? {divisor_high_byte, divisor_low_byte} // [RULE7] [RULE10]
      : {8'h00, divisor_low_byte}; // [RULE2]

   always @* begin
      if (sync_mode_select) begin
         prescale_sel = `SBRG_PSEL_4; // [RULE6] [RULE11] [RULE12]
      end else begin
         case ({wide_divisor_select, high_speed_select})
            2'h0: prescale_sel = `SBRG_PSEL_64; // [RULE4]
            2'h2: prescale_sel = `SBRG_PSEL_16; // [RULE5]
            2'h1: prescale_sel = `SBRG_PSEL_16; // [RULE8] [RULE11]
            2'h3: prescale_sel = `SBRG_PSEL_4; // [RULE8]
            default: prescale_sel = `SBRG_PSEL_64;
         endcase
      end
   end

   // ****************************************************************
   // rate divider
   // ****************************************************************
   // mode bit changes do not restart; only divisor byte writes with lane 0 strobed do
   sbrg_div sbrg_div_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(wr_high || wr_low), // [RULE3] [RULE9]
      .divisor(baud_divisor),
      .prescale_sel(prescale_sel),
      .rate_tick(rate_tick),
      .pre_count(pre_count),
      .rate_count(rate_count)
   );

   // ****************************************************************
   // read channel
   // ****************************************************************
   reg [31:0] next_rdata;
   reg [1:0] next_rresp;

   assign s_axi_arready = !s_axi_rvalid;

   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `SBRG_RESP_OKAY;
      case (s_axi_araddr[7:2])
         `SBRG_IDX_LOW: next_rdata[7:0] = divisor_low_byte;
         `SBRG_IDX_HIGH: next_rdata[7:0] = divisor_high_byte;
         `SBRG_IDX_CTRL: next_rdata[`SBRG_CTRL_MSB:0] = baud_control_reg;
         `SBRG_IDX_STAT: begin
            next_rdata[`SBRG_STAT_CNT_MSB:`SBRG_STAT_CNT_LSB] = rate_count;
            next_rdata[`SBRG_STAT_PRE_MSB:`SBRG_STAT_PRE_LSB] = pre_count;
         end
         default: next_rresp = `SBRG_RESP_SLVERR;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SBRG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // sbrg_top

// ### test/sbrg_properties.sv
/* bus handshake and rate tick checker
   bound onto sbrg_top: one clock, synchronous active-low reset */
`timescale 1ns/1ps
module sbrg_chk (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire rate_tick
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ****************
   // properties
   // ****************
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer not held");
   b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not released");
   w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   // both halves are held one cycle before the store, so the answer rises two edges on
   w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer not held");
   r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   tick_gap_a: assert property (rate_tick |=> !rate_tick [*3])
      else $error("ticks closer than four cycles");
endmodule // sbrg_chk

bind sbrg_top sbrg_chk sbrg_chk_i (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .rate_tick(rate_tick)
);

// ### test/sbrg_top_tb.sv
/* self-checking bench of sbrg_top over its bus and rate tick
   assumes sbrg_map.vh on the include path */
`timescale 1ns/1ps
`include "sbrg_map.vh"
module sbrg_top_tb;
   reg aclk;
   reg aresetn = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg [7:0] s_axi_araddr = 8'h00;
   reg [2:0] s_axi_awprot = 3'h0;
   reg [2:0] s_axi_arprot = 3'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'h0;
   reg s_axi_awvalid = 1'b0;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rate_tick, sync_mode;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer seed = 94030;
   integer mismatches = 0;
   integer comparisons = 0;
   integer cyc = 0;
   integer i, p, n;
   reg wr_busy = 1'b1;
   reg bv_d = 1'b0;
   reg [7:0] lo, hi;
   reg [33:0] cnt = 34'h0;
   reg [33:0] rq[$];
   reg [33:0] bq[$];
   reg [33:0] tq[$];
   reg [33:0] sq[$];

   sbrg_top sbrg_top_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(s_axi_awprot),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(s_axi_arprot),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .rate_tick(rate_tick),
      .sync_mode(sync_mode)
   );

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task chk(input [33:0] e, input [33:0] g);
      begin
         comparisons = comparisons + 1;
         if (e !== g) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
         end
      end
   endtask

   task chk_rd(input [33:0] e, input [33:0] g);
      begin
         chk(e, g);
      end
   endtask

   task chk_wr(input [33:0] e, input [33:0] g);
      begin
         chk(e, g);
      end
   endtask

   task chk_mode(input [33:0] e, input [33:0] g);
      begin
         chk(e, g);
      end
   endtask

   task chk_tick(input [33:0] e, input [33:0] g);
      begin
         chk(e, g);
      end
   endtask

   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask

   // ****************
   // bus master tasks
   // ****************
   task wr(input [7:0] a, input [7:0] d, input [3:0] s, input [1:0] r);
      reg ad, wd, ta, tw;
      begin
         @(posedge aclk);
         wr_busy = 1'b1;
         bq.push_back({r, 32'h0});
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'($random(seed)), d};
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         ad = 1'b0;
         wd = 1'b0;
         while (!(ad && wd)) begin
            @(negedge aclk);
            ta = s_axi_awready & s_axi_awvalid;
            tw = s_axi_wready & s_axi_wvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            ad = ad | ta;
            wd = wd | tw;
         end
         ta = 1'b0;
         while (!ta) begin
            @(negedge aclk);
            ta = s_axi_bvalid & s_axi_bready;
            @(posedge aclk);
            s_axi_bready <= !ta;
         end
      end
   endtask

   task rd(input [7:0] a, input [33:0] e);
      reg t;
      begin
         @(posedge aclk);
         rq.push_back(e);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         t = 1'b0;
         while (!t) begin
            @(negedge aclk);
            t = s_axi_arready;
            @(posedge aclk);
            s_axi_arvalid <= !t;
         end
         t = 1'b0;
         while (!t) begin
            @(negedge aclk);
            t = s_axi_rvalid & s_axi_rready;
            @(posedge aclk);
            s_axi_rready <= !t;
         end
      end
   endtask

   // ****************
   // monitors
   // ****************
   // ticks seen during a write are skipped: the divider may restart under them
   always @(negedge aclk) begin
      bv_d <= s_axi_bvalid;
      cnt = (s_axi_bvalid && !bv_d) ? 34'h0 : cnt + 34'h1;
      if (s_axi_rvalid && s_axi_rready) chk_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready) chk_wr(bq.pop_front(), {s_axi_bresp, 32'h0});
      if (sq.size() > 0) chk_mode(sq.pop_front(), {33'h0, sync_mode});
      if (rate_tick && !wr_busy) begin
         if (tq.size() > 0) chk_tick(tq.pop_front(), cnt);
         cnt = 34'h0;
      end
   end

   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         mismatches = mismatches + 1;
         print_verdict;
      end
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SBRG_OFS_LOW, 34'h0);
      rd(`SBRG_OFS_HIGH, 34'h0);
      $display("test 1 ended");
      hi = 8'($random(seed)) | 8'h01;
      wr(`SBRG_OFS_HIGH, hi, 4'hF, `SBRG_RESP_OKAY);
      rd(`SBRG_OFS_HIGH, {`SBRG_RESP_OKAY, 24'h0, hi});
      wr(`SBRG_OFS_HIGH, ~hi, 4'h0, `SBRG_RESP_OKAY);
      rd(`SBRG_OFS_HIGH, {`SBRG_RESP_OKAY, 24'h0, hi});
      wr(8'h10, hi, 4'hF, `SBRG_RESP_SLVERR);
      rd(8'h10, {`SBRG_RESP_SLVERR, 32'h0});
      // a mid-run reset must bring the high byte back to zero
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SBRG_OFS_HIGH, 34'h0);
      $display("test 2 ended");
      for (i = 0; i < 8; i = i + 1) begin
         lo = {5'h0, 3'($random(seed))};
         n = i[0] ? 256 + lo : lo;
         p = (i[2] || (i[0] && i[1])) ? 4 : (i[0] || i[1]) ? 16 : 64;
         wr(`SBRG_OFS_CTRL, {5'h0, i[2:0]}, 4'hF, `SBRG_RESP_OKAY);
         sq.push_back({33'h0, i[2]});
         // the later divisor write must restart the count
         if (i[1]) begin
            wr(`SBRG_OFS_HIGH, 8'h01, 4'hF, `SBRG_RESP_OKAY);
            wr(`SBRG_OFS_LOW, lo, 4'hF, `SBRG_RESP_OKAY);
         end else begin
            wr(`SBRG_OFS_LOW, lo, 4'hF, `SBRG_RESP_OKAY);
            wr(`SBRG_OFS_HIGH, 8'h01, 4'hF, `SBRG_RESP_OKAY);
         end
         tq.push_back(34'(p * (n + 1)));
         tq.push_back(34'(p * (n + 1)));
         wr_busy = 1'b0;
         while (tq.size() > 0) @(posedge aclk);
         $display("mode %0d ended", i);
      end
      print_verdict;
   end
endmodule // sbrg_top_tb
